// ===== rtl/rso_consts.svh
// Offsets, field positions, reset values and timing counts of the reset supervisor
`ifndef RSO_CONSTS_SVH
`define RSO_CONSTS_SVH

// Clock rate in MHz, so every count below is a whole number of cycles
`define RSO_CLK_MHZ 20

// Times in microseconds
`define RSO_FILTER_US 10
`define RSO_EXT_DELAY_US 10000
`define RSO_RED_DELAY_US 2000

// Times in ref_clk cycles
`define RSO_RF_CYC (`RSO_FILTER_US * `RSO_CLK_MHZ)
`define RSO_RD1_CYC (`RSO_EXT_DELAY_US * `RSO_CLK_MHZ)
`define RSO_RD2_CYC (`RSO_RED_DELAY_US * `RSO_CLK_MHZ)

// Register offsets
`define RSO_ADDR_CTRL 4'h0
`define RSO_ADDR_MODE 4'h1
`define RSO_ADDR_STAT 4'h2
`define RSO_ADDR_IRQ_STAT 4'h3
`define RSO_ADDR_IRQ_CLR 4'h4
`define RSO_ADDR_IRQ_EN 4'h5

// Control register fields
`define RSO_CTRL_SHORT_DLY 0
`define RSO_CTRL_THR_LSB 1
`define RSO_CTRL_THR_MSB 2
`define RSO_CTRL_SR_SUPPRESS 3
`define RSO_CTRL_WD_FAILSAFE 4
`define RSO_CTRL_RESET 8'h00

// Mode field values written to the mode register
`define RSO_MODE_WR_NORMAL 2'h0
`define RSO_MODE_WR_STOP 2'h1
`define RSO_MODE_WR_SOFT_RESET 2'h3

// Interrupt status bits
`define RSO_IRQ_RST_ASSERT 0
`define RSO_IRQ_WD_FAULT 1
`define RSO_IRQ_SOFT_RESET 2
`define RSO_IRQ_UNDERVOLT 3
`define RSO_IRQ_RESET 4'h0

// Watchdog failure count saturation
`define RSO_WDF_MAX 2'h2

`endif

// ===== rtl/rso_pkg.sv
// Types shared by the reset supervisor modules
package rso_pkg;

  // Device operating modes
  typedef enum logic [2:0] {
    RSO_INIT,
    RSO_NORMAL,
    RSO_STOP,
    RSO_RESTART,
    RSO_FAIL_SAFE
  } rso_mode_e;

  typedef logic [7:0] rso_data_t;

endpackage

// ===== rtl/rso_tmr_if.sv
// Control and status bundle between the supervisor and one of its delay timers
interface rso_tmr_if #(
  parameter int W = 20
);
  logic load;
  logic run;
  logic [W-1:0] len;
  logic expired;

  modport ctl (output load, output run, output len, input expired);
  modport tmr (input load, input run, input len, output expired);
endinterface

// ===== rtl/rso_timer.sv
// Loadable down counter used for the filter time and the release delays
module rso_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Timer control
  rso_tmr_if.tmr tif
);

  logic [W-1:0] cnt_reg;

  // Reset loads the full length so a timer never starts out already expired
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_reg <= tif.len;
    end else if (tif.load) begin
      cnt_reg <= tif.len;
    end else if (tif.run && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign tif.expired = tif.run && (cnt_reg == '0);

endmodule // rso_timer

// ===== rtl/rso_sync.sv
// Three-stage synchroniser; the output follows once the last two stages agree
module rso_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Asynchronous input and clean output
  input wire logic async_in,
  output logic sync_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;

  // Shift chain; only the second stage reads the first
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a change only when two settled stages agree
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      out_reg <= RST_VAL;
    end else if (s2_reg == s3_reg) begin
      out_reg <= s3_reg;
    end
  end

  assign sync_out = out_reg;

endmodule // rso_sync

// ===== rtl/rso_top.sv
// Reset output supervisor with soft reset, register port and interrupt
`include "rso_consts.svh"

// Function
// - Reset event drives reset output low (undervoltage after filter, watchdog and soft reset at once), held until release delay ends.
// - Release delay is extended by default, reduced when short-delay select is set.
// - At power-up reset stays low until supply is good, then extended delay.
// - Watchdog failure is a reset event just like main supply undervoltage.
// - Undervoltage threshold is software selectable and resets to the default setting.
// - Mode field value 11 requests soft reset, accepted only in Normal or Stop.
// - Valid soft reset returns to Init and restores registers to defaults; interrupt status holds only flags set in that cycle.
// - Suppress bit clear: soft reset asserts reset output with the extended delay.
// - Suppress bit set: soft reset leaves the reset output released.
// - Soft reset command in any other mode is ignored without effect.
// - Watchdog reset enters Restart or Fail-Safe per configuration, counts failures.
// - Watchdog long open window starts as soon as reset output goes high.
module rso_top
  import rso_pkg::*;
#(
  parameter int CW = 20,
  parameter int RF_CYC = `RSO_RF_CYC,
  parameter int RD1_CYC = `RSO_RD1_CYC,
  parameter int RD2_CYC = `RSO_RD2_CYC,
  parameter logic [1:0] WDF_MAX = `RSO_WDF_MAX
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output rso_data_t reg_rdata,
  // Supply monitor
  input wire logic main_regulator_uv,
  output logic [1:0] reset_threshold_sel,
  // Watchdog link
  input wire logic wd_fault,
  input wire logic wd_trigger_ok,
  output logic wd_long_window_start,
  // Reset output and status
  output logic reset_output_low_active,
  output logic [2:0] device_mode,
  output logic irq
);

  // Timer bundles for the filter time and the release delay
  rso_tmr_if #(.W(CW)) filt_if ();
  rso_tmr_if #(.W(CW)) dly_if ();

  // Register state
  rso_data_t ctrl_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_en_reg;
  rso_mode_e mode_reg;
  rso_mode_e mode_next;
  logic [1:0] watchdog_failure_count_reg;
  rso_data_t rdata_reg;

  // Reset output state
  logic rst_low_reg;
  logic long_sel_reg;
  logic uv_filt_prev_reg;
  logic release_reg;

  // Decoded strobes and derived events
  logic uv_sync;
  logic uv_filt;
  logic uv_rise;
  logic mode_wr;
  logic soft_req;
  logic soft_ok;
  logic soft_assert;
  logic event_now;
  logic release_now;
  logic short_delay_select;
  logic [3:0] irq_set;

  // Supply comparator output comes from the analog side, outside the clock domain
  rso_sync #(.RST_VAL(1'b1)) u_uv_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(main_regulator_uv),
    .sync_out(uv_sync)
  );

  // Undervoltage must persist for the whole filter time before it counts
  assign filt_if.load = !uv_sync;
  assign filt_if.run = uv_sync;
  assign filt_if.len = CW'(RF_CYC);

  rso_timer #(.W(CW)) u_filt (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tif(filt_if)
  );

  assign uv_filt = filt_if.expired;

  // Control fields
  assign short_delay_select = ctrl_reg[`RSO_CTRL_SHORT_DLY];
  assign reset_threshold_sel = ctrl_reg[`RSO_CTRL_THR_MSB:`RSO_CTRL_THR_LSB];

  // Soft reset decode; only Normal and Stop accept it, elsewhere it does nothing
  assign mode_wr = reg_wr && (reg_addr == `RSO_ADDR_MODE);
  assign soft_req = mode_wr && (reg_wdata[1:0] == `RSO_MODE_WR_SOFT_RESET);
  assign soft_ok = soft_req && (mode_reg == RSO_NORMAL || mode_reg == RSO_STOP);
  assign soft_assert = soft_ok && !ctrl_reg[`RSO_CTRL_SR_SUPPRESS];

  // Anything that pulls the reset output low this cycle
  assign event_now = uv_filt || wd_fault || soft_assert;

  // Release delay: held at full length while an event is present
  assign dly_if.load = event_now;
  assign dly_if.run = rst_low_reg && !event_now;
  // The soft reset edge itself must load the extended length; the select flag only follows a cycle later
  assign dly_if.len = (long_sel_reg || soft_assert || !short_delay_select) ? CW'(RD1_CYC) : CW'(RD2_CYC);

  rso_timer #(.W(CW)) u_dly (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tif(dly_if)
  );

  assign release_now = dly_if.expired;

  // Reset output: low from power-up, low on any event, high once the delay ends
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rst_low_reg <= 1'b1;
    end else if (event_now) begin
      rst_low_reg <= 1'b1;
    end else if (release_now) begin
      rst_low_reg <= 1'b0;
    end
  end

  // Power-up and soft reset always use the extended delay, whatever the select bit says
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      long_sel_reg <= 1'b1;
    end else if (soft_assert) begin
      long_sel_reg <= 1'b1;
    end else if (release_now) begin
      long_sel_reg <= 1'b0;
    end
  end

  // One-cycle start of the watchdog long open window at release
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      release_reg <= 1'b0;
    end else begin
      release_reg <= release_now;
    end
  end

  // Mode sequencing
  always_comb begin
    mode_next = mode_reg;
    if (soft_ok) begin
      mode_next = RSO_INIT;
    end else if (wd_fault) begin
      mode_next = ctrl_reg[`RSO_CTRL_WD_FAILSAFE] ? RSO_FAIL_SAFE : RSO_RESTART;
    end else if (release_now && mode_reg == RSO_RESTART) begin
      mode_next = RSO_NORMAL;
    end else if (mode_wr && !rst_low_reg) begin
      unique case (mode_reg)
        RSO_INIT, RSO_NORMAL, RSO_STOP: begin
          if (reg_wdata[1:0] == `RSO_MODE_WR_NORMAL) begin
            mode_next = RSO_NORMAL;
          end else if (reg_wdata[1:0] == `RSO_MODE_WR_STOP && mode_reg != RSO_INIT) begin
            mode_next = RSO_STOP;
          end
        end
        RSO_RESTART, RSO_FAIL_SAFE: begin
          mode_next = mode_reg;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_reg <= RSO_INIT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Control register; soft reset puts back the defaults
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_reg <= `RSO_CTRL_RESET;
    end else if (soft_ok) begin
      ctrl_reg <= `RSO_CTRL_RESET;
    end else if (reg_wr && reg_addr == `RSO_ADDR_CTRL) begin
      ctrl_reg <= {3'h0, reg_wdata[4:0]};
    end
  end

  // Watchdog failure count saturates; a failure wins over a same-cycle good trigger
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      watchdog_failure_count_reg <= 2'h0;
    end else if (wd_fault) begin
      if (watchdog_failure_count_reg != WDF_MAX) begin
        watchdog_failure_count_reg <= watchdog_failure_count_reg + 2'h1;
      end
    end else if (soft_ok || wd_trigger_ok) begin
      watchdog_failure_count_reg <= 2'h0;
    end
  end

  // Rising edge of the filtered undervoltage for the interrupt
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      uv_filt_prev_reg <= 1'b0;
    end else begin
      uv_filt_prev_reg <= uv_filt;
    end
  end

  assign uv_rise = uv_filt && !uv_filt_prev_reg;

  // Interrupt sources
  always_comb begin
    irq_set = 4'h0;
    irq_set[`RSO_IRQ_RST_ASSERT] = event_now && !rst_low_reg;
    irq_set[`RSO_IRQ_WD_FAULT] = wd_fault;
    irq_set[`RSO_IRQ_SOFT_RESET] = soft_ok;
    irq_set[`RSO_IRQ_UNDERVOLT] = uv_rise;
  end

  // Sticky status; a set in the clearing cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_stat_reg <= `RSO_IRQ_RESET;
    end else if (soft_ok) begin
      irq_stat_reg <= irq_set;
    end else if (reg_wr && reg_addr == `RSO_ADDR_IRQ_CLR) begin
      irq_stat_reg <= (irq_stat_reg & ~reg_wdata[3:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  // Interrupt enable
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_en_reg <= `RSO_IRQ_RESET;
    end else if (soft_ok) begin
      irq_en_reg <= `RSO_IRQ_RESET;
    end else if (reg_wr && reg_addr == `RSO_ADDR_IRQ_EN) begin
      irq_en_reg <= reg_wdata[3:0];
    end
  end

  // Read data stand in the cycle after the read strobe only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `RSO_ADDR_CTRL: rdata_reg <= ctrl_reg;
        `RSO_ADDR_STAT: rdata_reg <= {2'h0, watchdog_failure_count_reg, mode_reg, rst_low_reg};
        `RSO_ADDR_IRQ_STAT: rdata_reg <= {4'h0, irq_stat_reg};
        `RSO_ADDR_IRQ_EN: rdata_reg <= {4'h0, irq_en_reg};
        default: rdata_reg <= 8'h00; // Write-only and unmapped read as zero
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // Outputs
  assign reg_rdata = rdata_reg;
  assign reset_output_low_active = !rst_low_reg;
  assign wd_long_window_start = release_reg;
  assign device_mode = mode_reg;
  assign irq = |(irq_stat_reg & irq_en_reg);

endmodule // rso_top

// ===== verif/rso_top_props.sv
// Concurrent checks on the reset supervisor top ports
module rso_top_props
  import rso_pkg::*;
#(
  parameter int RF_CYC = 4,
  parameter int RD1_CYC = 40,
  parameter int RD2_CYC = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Supply and watchdog
  input wire logic main_regulator_uv,
  input wire logic [1:0] reset_threshold_sel,
  input wire logic wd_fault,
  input wire logic wd_long_window_start,
  // Reset output and mode
  input wire logic reset_output_low_active,
  input wire logic [2:0] device_mode
);
  logic [1:0] ctl_reg;
  logic sr_ok;
  int low_cnt;
  int uv_cnt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Soft reset write that the device must accept
  assign sr_ok = reg_wr && reg_addr == 4'h1 && reg_wdata[1:0] == 2'h3 && reset_output_low_active
                 && (device_mode == RSO_NORMAL || device_mode == RSO_STOP);

  // Mirror of suppress and short-delay bits; cleared on reset and on a soft reset accepted while the reset output is released
  always_ff @(posedge ref_clk) begin
    if (!resetn || sr_ok) begin
      ctl_reg <= 2'h0;
    end else if (reg_wr && reg_addr == 4'h0) begin
      ctl_reg <= {reg_wdata[3], reg_wdata[0]};
    end
  end

  // Cycle counters; kept through reset so a rise after reset still sees a long low time
  always_ff @(posedge ref_clk) begin
    low_cnt <= reset_output_low_active ? 0 : low_cnt + 1;
  end
  always_ff @(posedge ref_clk) begin
    uv_cnt <= main_regulator_uv ? uv_cnt + 1 : 0;
  end

  a_wd_fault_reset: assert property (wd_fault |=> !reset_output_low_active)
    else $error("watchdog failure did not assert reset");
  a_wd_mode_entry: assert property (wd_fault |=> device_mode inside {RSO_RESTART, RSO_FAIL_SAFE})
    else $error("watchdog failure did not enter restart or fail-safe");
  a_release_delay_min: assert property ($rose(reset_output_low_active) |->
    low_cnt >= (ctl_reg[0] ? RD2_CYC : RD1_CYC))
    else $error("reset released before the delay ran out");
  a_long_window: assert property ($rose(reset_output_low_active) |->
    wd_long_window_start ##1 !wd_long_window_start)
    else $error("long window start pulse wrong");
  a_uv_holds_reset: assert property (uv_cnt > RF_CYC + 8 |-> !reset_output_low_active)
    else $error("lasting undervoltage did not assert reset");
  a_soft_rst_out: assert property (sr_ok && !ctl_reg[1] |=> !reset_output_low_active)
    else $error("soft reset did not assert reset");
  a_soft_suppress: assert property (sr_ok && ctl_reg[1] |=> reset_output_low_active)
    else $error("suppressed soft reset asserted reset");
  a_soft_defaults: assert property (sr_ok |=> device_mode == RSO_INIT && reset_threshold_sel == 2'h0)
    else $error("soft reset did not restore defaults");
  a_soft_ignored: assert property (reg_wr && reg_addr == 4'h1 && reg_wdata[1:0] == 2'h3
    && device_mode == RSO_INIT && !wd_fault |=> $stable(device_mode))
    else $error("soft reset in init changed the mode");
endmodule // rso_top_props

bind rso_top rso_top_props #(.RF_CYC(RF_CYC), .RD1_CYC(RD1_CYC), .RD2_CYC(RD2_CYC)) u_props (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .main_regulator_uv(main_regulator_uv), .reset_threshold_sel(reset_threshold_sel), .wd_fault(wd_fault),
  .wd_long_window_start(wd_long_window_start), .reset_output_low_active(reset_output_low_active),
  .device_mode(device_mode)
);

// ===== verif/rso_mcu_model.sv
// Microcontroller model driving the register port
module rso_mcu_model
  import rso_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire rso_data_t reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; the slave never stalls
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask
endmodule // rso_mcu_model

// ===== verif/testbench.sv
// Self-checking bench for the reset output supervisor
module testbench;
  import rso_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RF = 4;
  localparam int RD1 = 40;
  localparam int RD2 = 20;
  typedef struct {logic [7:0] w; logic [1:0] thr;} rso_row_s;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic uv = 1'b0;
  logic wd_fault = 1'b0;
  logic wd_ok = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  rso_data_t reg_rdata;
  logic [1:0] thr;
  logic lws;
  logic rst_out;
  logic [2:0] mode;
  logic irq;
  logic [7:0] d;
  int n;
  int miscompares = 0;
  int checks_done = 0;
  rso_row_s rows [4] = '{'{8'h00, 2'h0}, '{8'h02, 2'h1}, '{8'h04, 2'h2}, '{8'h06, 2'h3}};

  rso_top #(.RF_CYC(RF), .RD1_CYC(RD1), .RD2_CYC(RD2)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_regulator_uv(uv), .reset_threshold_sel(thr),
    .wd_fault(wd_fault), .wd_trigger_ok(wd_ok), .wd_long_window_start(lws),
    .reset_output_low_active(rst_out), .device_mode(mode), .irq(irq));
  rso_mcu_model mcu (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Clock at 20 MHz
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string s);
    checks_done++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s took %0d", $time, s, got);
    end
  endtask

  // Bounded wait for release; looks just after each edge so the output has settled
  task automatic wait_rel(output int c);
    c = 0;
    while (rst_out !== 1'b1 && c < 500) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    if (c >= 500) begin
      miscompares++;
      $display("CHECK FAILED at %0t: reset release timed out", $time);
      print_verdict();
    end
  endtask

  task automatic pulse_wd();
    @(posedge ref_clk);
    wd_fault <= 1'b1;
    @(posedge ref_clk);
    wd_fault <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    wait_rel(n);
    chk_rng(n, RD1, RD1 + 8, "power-up");
    foreach (rows[i]) begin
      mcu.wr(4'h0, rows[i].w);
      #1;
      chk(8'(thr), 8'(rows[i].thr), "threshold");
      mcu.rd(4'h0, d);
      chk(d, rows[i].w, "ctrl");
    end
    mcu.rd(4'hF, d);
    chk(d, 8'h00, "unmapped");
    mcu.wr(4'h1, 8'h03);
    #1;
    chk(8'(mode), 8'(RSO_INIT), "init soft reset");
    chk(8'(thr), 8'h03, "ctrl kept");
    mcu.wr(4'h1, 8'h00);
    mcu.wr(4'h0, 8'h0C);
    mcu.wr(4'h1, 8'h03);
    #1;
    chk(8'(mode), 8'(RSO_INIT), "soft mode");
    chk(8'(thr), 8'h00, "soft thr");
    chk(8'(rst_out), 8'h01, "suppressed");
    mcu.rd(4'h3, d);
    chk(d, 8'h04, "soft irq status");
    mcu.wr(4'h1, 8'h00);
    mcu.wr(4'h0, 8'h01);
    mcu.wr(4'h1, 8'h01);
    #1;
    chk(8'(mode), 8'(RSO_STOP), "stop entry");
    mcu.wr(4'h1, 8'h03);
    #1;
    chk(8'(rst_out), 8'h00, "soft out");
    wait_rel(n);
    chk_rng(n, RD1, RD1 + 4, "soft delay");
    $display("soft reset done");
    mcu.wr(4'h1, 8'h00);
    mcu.wr(4'h5, 8'h02);
    pulse_wd();
    chk(8'(rst_out), 8'h00, "wd reset");
    chk(8'(mode), 8'(RSO_RESTART), "restart");
    wait_rel(n);
    chk_rng(n, RD1, RD1 + 4, "extended");
    #1;
    chk(8'(lws), 8'h01, "long window");
    chk(8'(irq), 8'h01, "irq");
    mcu.rd(4'h2, d);
    chk(d, 8'h12, "status");
    mcu.wr(4'h5, 8'h00);
    #1;
    chk(8'(irq), 8'h00, "masked");
    mcu.wr(4'h4, 8'h02);
    mcu.wr(4'h5, 8'h02);
    #1;
    chk(8'(irq), 8'h00, "cleared");
    @(posedge ref_clk);
    wd_ok <= 1'b1;
    @(posedge ref_clk);
    wd_ok <= 1'b0;
    mcu.rd(4'h2, d);
    chk(d, 8'h02, "count cleared");
    $display("watchdog done");
    mcu.wr(4'h0, 8'h01);
    pulse_wd();
    repeat (10) @(posedge ref_clk);
    pulse_wd();
    wait_rel(n);
    chk_rng(n, RD2, RD2 + 4, "restarted");
    @(posedge ref_clk);
    uv <= 1'b1;
    repeat (RF - 1) @(posedge ref_clk);
    uv <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk(8'(rst_out), 8'h01, "glitch");
    uv <= 1'b1;
    repeat (20) @(posedge ref_clk);
    uv <= 1'b0;
    #1;
    chk(8'(rst_out), 8'h00, "uv");
    wait_rel(n);
    chk_rng(n, RD2, RD2 + 8, "uv release");
    $display("undervoltage done");
    mcu.wr(4'h0, 8'h10);
    pulse_wd();
    chk(8'(mode), 8'(RSO_FAIL_SAFE), "fail-safe");
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk(8'(rst_out), 8'h00, "reset out");
    chk(8'(mode), 8'(RSO_INIT), "reset mode");
    $display("reset done");
    print_verdict();
  end
endmodule // testbench
